/* core/lt_frame_detect.v */
// one lane: training frame marker detector on the received word stream
// assumes one 16-bit received word per aclk when valid
`include "lt_status_defs.vh"

module lt_frame_detect (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire        word_valid,
  input  wire [15:0] word,
  output reg         marker_q
);
  always @(posedge aclk) begin
    if (!aresetn)
      marker_q <= 1'b0;
    else
      marker_q <= word_valid && (word == `LTS_SYNC_MARKER);
  end
endmodule

/* core/lt_lane_fsm.v */
// one lane: training state tracker, frame start and partner fields
// assumes frame marker and control/status words arrive aligned to aclk
`include "lt_status_defs.vh"

module lt_lane_fsm #(
  parameter TIMEOUT_CYC = `LTS_TIMEOUT_CYC
) (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire        start,
  input  wire        rx_marker_hit,
  input  wire        rx_ready,
  input  wire        rx_word_valid,
  input  wire [15:0] rx_ctrl_word,
  input  wire [15:0] rx_stat_word,
  output reg         active_q,
  output reg         done_q,
  output reg         timeout_q,
  output reg         sof_q,
  output reg         sync_q,
  output reg  [15:0] ctrl_q,
  output reg  [15:0] stat_q
);
  reg [1:0]  state_q;
  reg [31:0] tmo_cnt_q;
  reg [3:0]  lock_cnt_q;
  wire       expired;

  assign expired = (tmo_cnt_q == TIMEOUT_CYC - 1);

  always @(posedge aclk) begin
    if (!aresetn) begin
      state_q    <= `LTS_ST_IDLE;
      tmo_cnt_q  <= 32'h00000000;
      lock_cnt_q <= 4'h0;
      active_q   <= 1'b0; // [R11]
      done_q     <= 1'b0;
      timeout_q  <= 1'b0;
      sof_q      <= 1'b0;
      sync_q     <= 1'b0;
      ctrl_q     <= 16'h0000;
      stat_q     <= 16'h0000;
    end else begin
      sof_q <= rx_marker_hit && (state_q == `LTS_ST_TRAIN); // [R4]
      case (state_q)
        `LTS_ST_IDLE: begin
          if (start) begin
            state_q    <= `LTS_ST_TRAIN;
            tmo_cnt_q  <= 32'h00000000;
            lock_cnt_q <= 4'h0;
            active_q   <= 1'b1; // [R2]
            done_q     <= 1'b0;
            timeout_q  <= 1'b0;
            sync_q     <= 1'b0;
          end
        end
        `LTS_ST_TRAIN: begin
          tmo_cnt_q <= tmo_cnt_q + 32'h00000001;
          if (rx_marker_hit && lock_cnt_q != `LTS_LOCK_FRAMES)
            lock_cnt_q <= lock_cnt_q + 4'h1;
          if (lock_cnt_q == `LTS_LOCK_FRAMES)
            sync_q <= 1'b1; // [R5]
          if (rx_word_valid) begin
            ctrl_q <= rx_ctrl_word; // [R6] [R7] [R8]
            stat_q <= rx_stat_word; // [R9]
          end
          if (expired) begin
            state_q   <= `LTS_ST_FAIL;
            active_q  <= 1'b0;
            timeout_q <= 1'b1; // [R3]
          end else if (rx_ready && sync_q) begin
            state_q  <= `LTS_ST_SEND_DATA;
            active_q <= 1'b0;
            done_q   <= 1'b1; // [R1]
          end
        end
        `LTS_ST_SEND_DATA: begin
          if (!start)
            state_q <= `LTS_ST_IDLE;
        end
        `LTS_ST_FAIL: begin
          if (!start)
            state_q <= `LTS_ST_IDLE;
        end
        default: state_q <= `LTS_ST_IDLE;
      endcase
    end
  end
endmodule

/* core/lt_status_defs.vh */
// constants for the link training status block
// assumes inclusion by bare name from core design files
`ifndef LT_STATUS_DEFS_VH
`define LT_STATUS_DEFS_VH

`define LTS_ADDR_W          8
`define LTS_STATUS_OFF      8'h00
`define LTS_SYNC_OFF        8'h04
`define LTS_IRQ_STAT_OFF    8'h08
`define LTS_IRQ_MASK_OFF    8'h0C
`define LTS_COEF_OFF        8'h10
`define LTS_CTRL_OFF        8'h14
`define LTS_IRQ_MASK_RST    12'h000
`define LTS_CTRL_RST        32'h00000000
`define LTS_RESP_OKAY       2'b00
`define LTS_RESP_SLVERR     2'b10
`define LTS_ST_TRAIN        2'd1
`define LTS_ST_SEND_DATA    2'd2
`define LTS_ST_FAIL         2'd3
`define LTS_ST_IDLE         2'd0
`define LTS_TIMEOUT_MS      500
`define LTS_CLK_MHZ         200
`define LTS_TIMEOUT_CYC     (`LTS_TIMEOUT_MS * 1000 * `LTS_CLK_MHZ)
`define LTS_FRAME_CYC       16'h0100
`define LTS_SYNC_MARKER     16'hFF00
`define LTS_LOCK_FRAMES     4'h3

`endif

/* core/lt_status_top.v */
// four-lane link training status block with axi4-lite registers
// assumes receive words already decoded per lane, synchronous to aclk
//
// Notes on behaviour
// [R1] lane done flag on entering send data
// [R2] lane active flag while training runs
// [R3] lane timeout flag on training period expiry
// [R4] frame start strobe one cycle per frame
// [R5] frame sync flag once frames lock
// [R6] output last received preset request bit
// [R7] output last received initialize request bit
// [R8] three 2-bit tap requests per lane
// [R9] three 2-bit tap status fields per lane
// [R10] report receive recovery hold control
// [R11] reset clears status and partner fields
//
// The register offsets and the AXI4-Lite interface to the registers were decided locally.
`include "lt_status_defs.vh"

module lt_status_top #(
  parameter LANES       = 4,
  parameter TIMEOUT_CYC = `LTS_TIMEOUT_CYC
) (
  input  wire               aclk,
  input  wire               aresetn,
  input  wire [LANES-1:0]   train_start,
  input  wire [LANES-1:0]   rx_ready,
  input  wire [LANES-1:0]   rx_word_valid,
  input  wire [LANES*16-1:0] rx_word,
  input  wire [LANES*16-1:0] rx_ctrl_word,
  input  wire [LANES*16-1:0] rx_stat_word,
  output reg  [LANES-1:0]   lane_train_done,
  output reg  [LANES-1:0]   lane_train_active,
  output reg  [LANES-1:0]   lane_train_timeout,
  output reg  [LANES-1:0]   lane_train_frame_start,
  output reg  [LANES-1:0]   lane_train_frame_sync,
  output reg  [LANES-1:0]   partner_preset_req,
  output reg  [LANES-1:0]   partner_init_req,
  output reg  [LANES*2-1:0] partner_post_tap_req,
  output reg  [LANES*2-1:0] partner_main_tap_req,
  output reg  [LANES*2-1:0] partner_pre_tap_req,
  output reg  [LANES*2-1:0] partner_post_tap_status,
  output reg  [LANES*2-1:0] partner_main_tap_status,
  output reg  [LANES*2-1:0] partner_pre_tap_status,
  output reg                rx_recovery_hold_out,
  output reg                irq,
  input  wire [7:0]         s_axi_awaddr,
  input  wire               s_axi_awvalid,
  output reg                s_axi_awready,
  input  wire [31:0]        s_axi_wdata,
  input  wire [3:0]         s_axi_wstrb,
  input  wire               s_axi_wvalid,
  output reg                s_axi_wready,
  output reg  [1:0]         s_axi_bresp,
  output reg                s_axi_bvalid,
  input  wire               s_axi_bready,
  input  wire [7:0]         s_axi_araddr,
  input  wire               s_axi_arvalid,
  output reg                s_axi_arready,
  output reg  [31:0]        s_axi_rdata,
  output reg  [1:0]         s_axi_rresp,
  output reg                s_axi_rvalid,
  input  wire               s_axi_rready
);
  wire [LANES-1:0]    act_w;
  wire [LANES-1:0]    done_w;
  wire [LANES-1:0]    tmo_w;
  wire [LANES-1:0]    sof_w;
  wire [LANES-1:0]    sync_w;
  wire [LANES-1:0]    mark_w;
  wire [LANES*16-1:0] ctrl_w;
  wire [LANES*16-1:0] stat_w;
  reg  [LANES-1:0]    done_prev_q;
  reg  [LANES-1:0]    tmo_prev_q;
  reg  [LANES-1:0]    sync_prev_q;
  reg  [11:0]         irq_stat_q;
  reg  [11:0]         irq_mask_q;
  reg  [31:0]         ctrl_reg_q;
  reg  [LANES-1:0]    start_d;
  reg  [11:0]         irq_set_d;
  reg  [7:0]          aw_addr_q;
  reg  [31:0]         w_data_q;
  reg  [3:0]          w_strb_q;
  reg                 aw_have_q;
  reg                 w_have_q;
  reg  [31:0]         rd_d;
  reg                 rd_ok_d;
  reg  [11:0]         w1c_d;
  wire                wr_fire;

  genvar g;
  generate
    for (g = 0; g < LANES; g = g + 1) begin : lane
      lt_frame_detect u_det (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .word_valid (rx_word_valid[g]),
        .word       (rx_word[g*16 +: 16]),
        .marker_q   (mark_w[g])
      );
      lt_lane_fsm #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_fsm (
        .aclk          (aclk),
        .aresetn       (aresetn),
        .start         (start_d[g]),
        .rx_marker_hit (mark_w[g]),
        .rx_ready      (rx_ready[g]),
        .rx_word_valid (rx_word_valid[g]),
        .rx_ctrl_word  (rx_ctrl_word[g*16 +: 16]),
        .rx_stat_word  (rx_stat_word[g*16 +: 16]),
        .active_q      (act_w[g]),
        .done_q        (done_w[g]),
        .timeout_q     (tmo_w[g]),
        .sof_q         (sof_w[g]),
        .sync_q        (sync_w[g]),
        .ctrl_q        (ctrl_w[g*16 +: 16]),
        .stat_q        (stat_w[g*16 +: 16])
      );
      // partner word layout: [13] preset [12] init [5:4] post
      // [3:2] main [1:0] pre
      always @(posedge aclk) begin
        if (!aresetn) begin
          partner_preset_req[g]          <= 1'b0; // [R11]
          partner_init_req[g]            <= 1'b0;
          partner_post_tap_req[g*2 +: 2] <= 2'b00;
          partner_main_tap_req[g*2 +: 2] <= 2'b00;
          partner_pre_tap_req[g*2 +: 2]  <= 2'b00;
          partner_post_tap_status[g*2 +: 2] <= 2'b00;
          partner_main_tap_status[g*2 +: 2] <= 2'b00;
          partner_pre_tap_status[g*2 +: 2]  <= 2'b00;
        end else begin
          partner_preset_req[g] <= ctrl_w[g*16+13]; // [R6]
          partner_init_req[g]   <= ctrl_w[g*16+12]; // [R7]
          partner_post_tap_req[g*2 +: 2] <= ctrl_w[g*16+4 +: 2]; // [R8]
          partner_main_tap_req[g*2 +: 2] <= ctrl_w[g*16+2 +: 2]; // [R8]
          partner_pre_tap_req[g*2 +: 2]  <= ctrl_w[g*16 +: 2]; // [R8]
          partner_post_tap_status[g*2 +: 2] <= stat_w[g*16+4 +: 2]; // [R9]
          partner_main_tap_status[g*2 +: 2] <= stat_w[g*16+2 +: 2]; // [R9]
          partner_pre_tap_status[g*2 +: 2]  <= stat_w[g*16 +: 2]; // [R9]
        end
      end
    end
  endgenerate

  // start from pin or software control bits
  always @* begin
    start_d = train_start | ctrl_reg_q[LANES-1:0];
  end

  // lane status outputs, registered
  always @(posedge aclk) begin
    if (!aresetn) begin
      lane_train_done        <= {LANES{1'b0}}; // [R11]
      lane_train_active      <= {LANES{1'b0}};
      lane_train_timeout     <= {LANES{1'b0}};
      lane_train_frame_start <= {LANES{1'b0}};
      lane_train_frame_sync  <= {LANES{1'b0}};
      rx_recovery_hold_out   <= 1'b0;
      done_prev_q            <= {LANES{1'b0}};
      tmo_prev_q             <= {LANES{1'b0}};
      sync_prev_q            <= {LANES{1'b0}};
    end else begin
      lane_train_done        <= done_w; // [R1]
      lane_train_active      <= act_w; // [R2]
      lane_train_timeout     <= tmo_w; // [R3]
      lane_train_frame_start <= sof_w; // [R4]
      lane_train_frame_sync  <= sync_w; // [R5]
      // hold recovery while any lane trains or while forced by control bit 8
      rx_recovery_hold_out   <= ctrl_reg_q[8] | (|act_w); // [R10]
      done_prev_q            <= done_w;
      tmo_prev_q             <= tmo_w;
      sync_prev_q            <= sync_w;
    end
  end

  // interrupt events: done, timeout, sync rising per lane
  always @* begin
    irq_set_d = {sync_w & ~sync_prev_q, tmo_w & ~tmo_prev_q,
                 done_w & ~done_prev_q};
  end

  assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;

  always @* begin
    w1c_d = 12'h000;
    if (wr_fire && aw_addr_q == `LTS_IRQ_STAT_OFF && w_strb_q[0])
      w1c_d[7:0] = w_data_q[7:0];
    if (wr_fire && aw_addr_q == `LTS_IRQ_STAT_OFF && w_strb_q[1])
      w1c_d[11:8] = w_data_q[11:8];
  end

  // axi4-lite write path, address and data in either order
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `LTS_RESP_OKAY;
      aw_have_q     <= 1'b0;
      w_have_q      <= 1'b0;
      aw_addr_q     <= 8'h00;
      w_data_q      <= 32'h00000000;
      w_strb_q      <= 4'h0;
      irq_stat_q    <= 12'h000;
      irq_mask_q    <= `LTS_IRQ_MASK_RST;
      ctrl_reg_q    <= `LTS_CTRL_RST;
      irq           <= 1'b0;
    end else begin
      s_axi_awready <= !aw_have_q && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_have_q && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `LTS_RESP_OKAY;
        case (aw_addr_q)
          `LTS_IRQ_MASK_OFF: begin
            if (w_strb_q[0])
              irq_mask_q[7:0] <= w_data_q[7:0];
            if (w_strb_q[1])
              irq_mask_q[11:8] <= w_data_q[11:8];
          end
          `LTS_CTRL_OFF: begin
            if (w_strb_q[0])
              ctrl_reg_q[7:0] <= w_data_q[7:0] & 8'h0F;
            if (w_strb_q[1])
              ctrl_reg_q[15:8] <= w_data_q[15:8] & 8'h01;
          end
          `LTS_IRQ_STAT_OFF: s_axi_bresp <= `LTS_RESP_OKAY;
          default: s_axi_bresp <= `LTS_RESP_SLVERR;
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      // set wins over write-one clear
      irq_stat_q <= (irq_stat_q & ~w1c_d) | irq_set_d;
      irq        <= |(irq_stat_q & irq_mask_q);
    end
  end

  // read mux
  always @* begin
    rd_d    = 32'h00000000;
    rd_ok_d = 1'b1;
    case (s_axi_araddr)
      `LTS_STATUS_OFF:
        rd_d[11:0] = {tmo_w, act_w, done_w};
      `LTS_SYNC_OFF:
        rd_d[7:0] = {sof_w, sync_w};
      `LTS_IRQ_STAT_OFF: rd_d[11:0] = irq_stat_q;
      `LTS_IRQ_MASK_OFF: rd_d[11:0] = irq_mask_q;
      `LTS_COEF_OFF:
        rd_d[31:0] = {partner_post_tap_req, partner_main_tap_req,
                      partner_pre_tap_req, partner_post_tap_status};
      `LTS_CTRL_OFF: rd_d = ctrl_reg_q;
      default: rd_ok_d = 1'b0;
    endcase
  end

  // axi4-lite read path
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `LTS_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_d;
        s_axi_rresp  <= rd_ok_d ? `LTS_RESP_OKAY : `LTS_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule

/* verif/lt_partner_model.sv */
// partner model: four-lane training frame source, marker each frame
// assumes one received word per aclk per lane while enabled
`include "lt_status_defs.vh"
module lt_partner_model #(
  parameter PER = 256
) (
  input  wire        aclk,
  input  wire [3:0]  en,
  input  wire [63:0] ctrl_val,
  input  wire [63:0] stat_val,
  output reg  [3:0]  vld,
  output reg  [63:0] word,
  output reg  [63:0] ctrl,
  output reg  [63:0] stat
);
  timeunit 1ns;
  timeprecision 100ps;
  integer cnt = 0;
  integer i;
  initial begin
    vld = 4'h0;
    word = 64'h0;
    ctrl = 64'h0;
    stat = 64'h0;
  end
  // released lanes toggle so stale words never look valid
  always @(posedge aclk) begin
    cnt <= (cnt == PER - 1) ? 0 : cnt + 1;
    for (i = 0; i < 4; i = i + 1) begin
      vld[i] <= en[i];
      word[i*16+:16] <= !en[i] ? ~word[i*16+:16] :
        (cnt == 0) ? `LTS_SYNC_MARKER : cnt[15:0];
      ctrl[i*16+:16] <= en[i] ? ctrl_val[i*16+:16] : ~ctrl[i*16+:16];
      stat[i*16+:16] <= en[i] ? stat_val[i*16+:16] : ~stat[i*16+:16];
    end
  end
endmodule

/* verif/lt_status_assertions.sv */
// checker: timing relations seen at the status block ports
// assumes bind onto the top module, a single clock domain
module lt_status_assertions (
  input wire        aclk,
  input wire        aresetn,
  input wire [3:0]  train_start,
  input wire [3:0]  rx_ready,
  input wire [3:0]  rx_word_valid,
  input wire [63:0] rx_word,
  input wire [3:0]  lane_train_done,
  input wire [3:0]  lane_train_active,
  input wire [3:0]  lane_train_timeout,
  input wire [3:0]  lane_train_frame_start,
  input wire [3:0]  lane_train_frame_sync,
  input wire [7:0]  partner_pre_tap_req,
  input wire [7:0]  partner_post_tap_status,
  input wire        rx_recovery_hold_out
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  chk_sof_one: assert property (
    lane_train_frame_start[0] |=> !lane_train_frame_start[0])
    else $error("frame start longer than one cycle");
  chk_sof_cause: assert property (
    lane_train_frame_start[1] |->
      $past(rx_word_valid[1], 3) && $past(rx_word[31:16], 3) == 16'hFF00)
    else $error("frame start without marker");
  chk_done_excl: assert property (
    lane_train_done[2] |-> !lane_train_active[2] && !lane_train_timeout[2])
    else $error("done together with active or timeout");
  chk_active_rise: assert property (
    $rose(train_start[3]) |-> ##2 lane_train_active[3])
    else $error("active late after start");
  chk_timeout_act: assert property (
    $rose(lane_train_timeout[0]) |-> $past(lane_train_active[0]))
    else $error("timeout outside training");
  chk_done_ready: assert property (
    $rose(lane_train_done[1]) |-> $past(rx_ready[1], 2))
    else $error("done without receiver ready");
  chk_sync_act: assert property (
    $rose(lane_train_frame_sync[3]) |-> lane_train_active[3])
    else $error("sync before training");
  chk_hold_any: assert property (
    $rose(|lane_train_active) |-> ##[0:2] rx_recovery_hold_out)
    else $error("recovery hold missing while active");
  chk_field_cause: assert property (
    $changed(partner_pre_tap_req[1:0]) |-> $past(rx_word_valid[0]) ||
      $past(rx_word_valid[0], 2) || $past(rx_word_valid[0], 3))
    else $error("tap request changed without word");
  chk_reset_clr: assert property (disable iff (1'b0)
    !aresetn |=> lane_train_done == 4'h0 && lane_train_active == 4'h0 &&
      lane_train_timeout == 4'h0 && partner_post_tap_status == 8'h00)
    else $error("outputs not cleared by reset");
  cover property (lane_train_done == 4'hF);
  cover property (lane_train_timeout[2]);
  cover property ($rose(rx_recovery_hold_out));
endmodule

bind lt_status_top lt_status_assertions u_chk (.*);

/* verif/lt_status_top_tb_top.sv */
// testbench: training, timeout, interrupts, registers, reset
// assumes partner model drives the received word streams
`include "lt_status_defs.vh"
module lt_status_top_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [3:0]  train_start = 4'h0;
  logic [3:0]  rx_ready = 4'h0;
  logic [3:0]  en = 4'h0;
  logic [63:0] ctrl_val = 64'h0;
  logic [63:0] stat_val = 64'h0;
  logic [7:0]  s_axi_awaddr = 8'h00;
  logic [7:0]  s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_bready = 1'b1;
  logic        s_axi_rready = 1'b1;
  wire  [3:0]  rx_word_valid, lane_train_done, lane_train_active;
  wire  [3:0]  lane_train_timeout, lane_train_frame_start;
  wire  [3:0]  lane_train_frame_sync, partner_preset_req, partner_init_req;
  wire  [63:0] rx_word, rx_ctrl_word, rx_stat_word;
  wire  [7:0]  partner_post_tap_req, partner_main_tap_req;
  wire  [7:0]  partner_pre_tap_req, partner_post_tap_status;
  wire  [7:0]  partner_main_tap_status, partner_pre_tap_status;
  wire         rx_recovery_hold_out, irq, s_axi_awready, s_axi_wready;
  wire         s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire  [1:0]  s_axi_bresp, s_axi_rresp;
  wire  [31:0] s_axi_rdata;
  integer      seed = 83;
  integer      err_count = 0;
  integer      total_checks = 0;
  integer      cyc = 0;
  integer      i, k;
  logic        win = 1'b0;
  logic [63:0] last_c = 64'h0;
  logic [63:0] last_s = 64'h0;
  logic [3:0]  mk, ex;
  int          qt[$];
  logic [3:0]  qm[$];

  lt_status_top #(.TIMEOUT_CYC(2000)) DUT (.aclk, .aresetn, .train_start,
    .rx_ready, .rx_word_valid, .rx_word, .rx_ctrl_word, .rx_stat_word,
    .lane_train_done, .lane_train_active, .lane_train_timeout,
    .lane_train_frame_start, .lane_train_frame_sync, .partner_preset_req,
    .partner_init_req, .partner_post_tap_req, .partner_main_tap_req,
    .partner_pre_tap_req, .partner_post_tap_status,
    .partner_main_tap_status, .partner_pre_tap_status,
    .rx_recovery_hold_out, .irq, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  lt_partner_model #(.PER(`LTS_FRAME_CYC)) partner (.aclk, .en, .ctrl_val,
    .stat_val, .vld(rx_word_valid), .word(rx_word), .ctrl(rx_ctrl_word),
    .stat(rx_stat_word));

  initial forever #2.5 aclk = ~aclk;

  task chk_val(input string nm, input [63:0] e, input [63:0] g);
    total_checks = total_checks + 1;
    if (g !== e) begin
      err_count = err_count + 1;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task chk_resp(input string nm, input [2:0] e, input [2:0] g);
    total_checks = total_checks + 1;
    if (g !== e) begin
      err_count = err_count + 1;
      $display("[FAIL] %s response expected %h seen %h", nm, e, g);
    end
  endtask
  task wr(input [7:0] a, input [31:0] d, input [1:0] er);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    chk_resp("write", {1'b1, er}, {s_axi_bvalid, s_axi_bresp});
  endtask
  task rd(input string nm, input [7:0] a, input [31:0] e, input [31:0] m,
          input [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    chk_resp(nm, {1'b1, er}, {s_axi_rvalid, s_axi_rresp});
    chk_val(nm, e, s_axi_rdata & m);
  endtask
  task chk_fields;
    logic [63:0] e;
    e = 64'h0;
    for (k = 0; k < 4; k = k + 1) begin
      e[k] = last_c[k*16+13];
      e[4+k] = last_c[k*16+12];
      e[8+2*k+:2] = last_c[k*16+4+:2];
      e[16+2*k+:2] = last_c[k*16+2+:2];
      e[24+2*k+:2] = last_c[k*16+:2];
      e[32+2*k+:2] = last_s[k*16+4+:2];
      e[40+2*k+:2] = last_s[k*16+2+:2];
      e[48+2*k+:2] = last_s[k*16+:2];
    end
    chk_val("partner fields", e, {partner_pre_tap_status,
      partner_main_tap_status, partner_post_tap_status, partner_pre_tap_req,
      partner_main_tap_req, partner_post_tap_req, partner_init_req,
      partner_preset_req});
    rd("coef", `LTS_COEF_OFF, {e[15:8], e[23:16], e[31:24], e[39:32]},
       32'hFFFFFFFF, 2'b00);
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // model: marker seen now gives a frame start three edges later
  always @(posedge aclk) begin
    cyc = cyc + 1;
    mk = 4'h0;
    for (i = 0; i < 4; i = i + 1) begin
      mk[i] = rx_word_valid[i] && rx_word[i*16+:16] === `LTS_SYNC_MARKER;
      if (rx_word_valid[i]) begin
        last_c[i*16+:16] = rx_ctrl_word[i*16+:16];
        last_s[i*16+:16] = rx_stat_word[i*16+:16];
      end
    end
    if (mk != 4'h0) begin
      qt.push_back(cyc + 3);
      qm.push_back(mk);
    end
    ex = 4'h0;
    if (qt.size() > 0 && qt[0] == cyc) begin
      ex = qm.pop_front();
      void'(qt.pop_front());
    end
    if (win) chk_val("frame start", ex, lane_train_frame_start);
    if (cyc == 9000) begin
      err_count = err_count + 1;
      end_of_test;
    end
  end

  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk_val("outputs", 0, {lane_train_done, lane_train_active, irq,
      lane_train_timeout, lane_train_frame_sync, rx_recovery_hold_out});
    rd("mask", `LTS_IRQ_MASK_OFF, `LTS_IRQ_MASK_RST, 32'hFFFFFFFF, 2'b00);
    rd("ctrl", `LTS_CTRL_OFF, `LTS_CTRL_RST, 32'hFFFFFFFF, 2'b00);
    rd("unmapped", 8'h18, 32'h0, 32'h0, `LTS_RESP_SLVERR);
    wr(8'h20, 32'h1, `LTS_RESP_SLVERR);
    wr(`LTS_STATUS_OFF, 32'hFFF, `LTS_RESP_SLVERR);
    rd("status ro", `LTS_STATUS_OFF, 32'h0, 32'hFFF, `LTS_RESP_OKAY);
    $display("test registers done");
    ctrl_val <= {$random(seed), $random(seed)};
    stat_val <= {$random(seed), $random(seed)};
    en <= 4'hF;
    wr(`LTS_IRQ_MASK_OFF, 32'hF, `LTS_RESP_OKAY);
    train_start <= 4'hF;
    repeat (40) @(posedge aclk);
    win = 1'b1;
    repeat (1000) @(posedge aclk);
    win = 1'b0;
    chk_val("sync", 4'hF, lane_train_frame_sync);
    chk_val("active", 4'hF, lane_train_active);
    chk_val("hold", 1, rx_recovery_hold_out);
    rx_ready <= 4'hF;
    for (k = 0; k < 100 && lane_train_done !== 4'hF; k = k + 1)
      @(posedge aclk);
    repeat (3) @(posedge aclk);
    chk_val("done", 12'hF00, {lane_train_done, lane_train_active,
      lane_train_timeout});
    chk_fields;
    chk_val("irq done", 1, irq);
    rd("status", `LTS_STATUS_OFF, 32'hF, 32'hFFF, 2'b00);
    wr(`LTS_IRQ_STAT_OFF, 32'hFFFFFFFF, `LTS_RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk_val("irq cleared", 0, irq);
    $display("test training done");
    train_start <= 4'h0;
    rx_ready <= 4'h0;
    repeat (5) @(posedge aclk);
    wr(`LTS_IRQ_STAT_OFF, 32'hFFFFFFFF, `LTS_RESP_OKAY);
    wr(`LTS_IRQ_MASK_OFF, 32'h0, `LTS_RESP_OKAY);
    ctrl_val <= {$random(seed), $random(seed)};
    stat_val <= {$random(seed), $random(seed)};
    en <= 4'b1011;
    train_start <= 4'hF;
    repeat (1800) @(posedge aclk);
    chk_val("early timeout", 0, lane_train_timeout);
    chk_val("partial sync", 4'b1011, lane_train_frame_sync);
    rd("sync reg", `LTS_SYNC_OFF, 32'hB, 32'hF, 2'b00);
    for (k = 0; k < 400 && lane_train_timeout !== 4'hF; k = k + 1)
      @(posedge aclk);
    repeat (3) @(posedge aclk);
    chk_val("timeout", 8'hF0, {lane_train_timeout, lane_train_done});
    chk_val("irq masked", 0, irq);
    rd("irq status", `LTS_IRQ_STAT_OFF, 32'hF0, 32'hFF, 2'b00);
    wr(`LTS_IRQ_MASK_OFF, 32'h40, `LTS_RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk_val("irq raised", 1, irq);
    wr(`LTS_IRQ_STAT_OFF, 32'h40, `LTS_RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk_val("irq w1c", 0, irq);
    chk_fields;
    $display("test timeout done");
    train_start <= 4'h0;
    repeat (5) @(posedge aclk);
    chk_val("hold idle", 0, rx_recovery_hold_out);
    s_axi_wstrb <= 4'h2;
    wr(`LTS_CTRL_OFF, 32'h10F, `LTS_RESP_OKAY);
    s_axi_wstrb <= 4'hF;
    repeat (2) @(posedge aclk);
    chk_val("hold forced", 1, rx_recovery_hold_out);
    chk_val("strobe lane", 0, lane_train_active);
    wr(`LTS_CTRL_OFF, 32'hF, `LTS_RESP_OKAY);
    repeat (10) @(posedge aclk);
    chk_val("sw start", 4'hF, lane_train_active);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    chk_val("reset outs", 0, {lane_train_active, rx_recovery_hold_out,
      partner_pre_tap_req, partner_post_tap_status, partner_init_req});
    aresetn <= 1'b1;
    repeat (5) @(posedge aclk);
    $display("test hold and reset done");
    end_of_test;
  end
endmodule
